// file: design/iar_params.svh
// Timing counts, register offsets and field positions for the integrating converter readout.
`ifndef IAR_PARAMS_SVH
`define IAR_PARAMS_SVH
`define IAR_CLOCK_MHZ          125
`define IAR_INT_CLK_MHZ        5
`define IAR_INTEGRATION_TOGGLE_LATENCY_US    276
`define IAR_INTEGRATION_TOGGLE_LATENCY_CYC   (`IAR_INTEGRATION_TOGGLE_LATENCY_US * `IAR_CLOCK_MHZ)
`define IAR_INTEGRATION_TOGGLE_TICKS         (`IAR_INTEGRATION_TOGGLE_LATENCY_US * `IAR_INT_CLK_MHZ)
`define IAR_CLKDIV_RATIO       4
`define IAR_SHIFT_HALF_CYC     4
`define IAR_INT_HALF_RESET     24'hF424
`define IAR_CHANS_RESET        10'h080
`define IAR_HEADROOM_NUM       4
`define IAR_HEADROOM_DEN       1000
`define IAR_WIDTH_WIDE         20
`define IAR_WIDTH_NARROW       16
`define IAR_CFG_CLKDIV         13
`define IAR_CFG_RANGE_HI       10
`define IAR_CFG_RANGE_LO       9
`define IAR_CFG_FORMAT         8
`define IAR_CFG_VERSION        7
`define IAR_REG_CTRL           8'h00
`define IAR_REG_INT_HALF       8'h04
`define IAR_REG_CHANS          8'h08
`define IAR_REG_STATUS         8'h0C
`define IAR_REG_IRQ_EN         8'h10
`define IAR_REG_IRQ_CLR        8'h14
`define IAR_CTRL_RUN           0
`define IAR_CTRL_FORMAT        1
`define IAR_CTRL_RANGE_LO      2
`define IAR_CTRL_RANGE_HI      3
`define IAR_CTRL_VERSION       4
`define IAR_CTRL_CLKDIV        5
`define IAR_CTRL_FIXED_WAIT    6
`define IAR_CTRL_EARLY_READ    7
`define IAR_EV_DONE            0
`define IAR_EV_READOUT         1
`define IAR_EV_OVERRUN         2
`endif

// file: design/iar_pkg.sv
// Types shared by both ends of the integrating converter readout.
package iar_pkg;
  typedef enum logic [2:0]
  {
    IAR_IDLE  = 3'b001,
    IAR_WAIT  = 3'b010,
    IAR_SHIFT = 3'b100
  } iar_state_e;
  typedef logic [15:0] iar_cfg_t;
  typedef logic [2:0]  iar_events_t;
endpackage

// file: design/iar_link_if.sv
// Pins between the converter and its controller.
`timescale 1ns/10ps
interface iar_link_if;
  import iar_pkg::*;
  logic     integration_toggle;
  logic     shift_clock;
  iar_cfg_t cfg_word;
  logic     conversion_done_n;
  logic     data_out;
  logic     chain_in;
  modport dev (input integration_toggle, input shift_clock, input cfg_word, input chain_in,
               output conversion_done_n, output data_out);
  modport ctrl (output integration_toggle, output shift_clock, output cfg_word,
                input conversion_done_n, input data_out);
endinterface

// file: design/iar_device.sv
// Converter end: integration edges, conversion timing, result coding and chained shift-out.
`timescale 1ns/10ps
`include "iar_params.svh"
module iar_device
  import iar_pkg::*;
#(
  parameter int CH         = 64,
  parameter int WMAX       = `IAR_WIDTH_WIDE,
  parameter int INTEGRATION_TOGGLE_TICKS = `IAR_INTEGRATION_TOGGLE_TICKS
)
(
  // Clock and reset.
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // Link to the controller.
  iar_link_if.dev                link,
  // Integrated charge per channel, signed, channel 0 in the low bits.
  input  wire logic [CH*(WMAX+1)-1:0] charge_i,
  // Conversion in progress.
  output logic                   integration_toggle_busy_o
);
  import iar_pkg::*;

  localparam int SR_W = CH * WMAX;
  localparam int HEAD = (2 ** WMAX) * `IAR_HEADROOM_NUM / `IAR_HEADROOM_DEN;

  logic              tog_prev_reg;
  logic              sc_prev_reg;
  logic [1:0]        div_reg;
  logic [15:0]       tick_cnt_reg;
  logic              busy_reg;
  logic              done_n_reg;
  logic [SR_W-1:0]   sr_reg;
  logic [SR_W-1:0]   load_vec;
  logic [SR_W-1:0]   shift_next;
  logic              int_edge;
  logic              tick;
  logic              finish;
  logic              sc_rise;
  logic              fmt_wide;

  // Headroom below zero.
  // Map a signed charge onto the output code; small negative charges still read above zero.
  function automatic logic [WMAX-1:0] iar_code(input logic signed [WMAX:0] q);
    logic signed [WMAX+1:0] sum;
    sum = '0;
    sum = $signed({q[WMAX], q}) + (WMAX+2)'(HEAD);
    if (sum < 0)
      iar_code = '0;
    else if (sum > $signed({2'b00, {WMAX{1'b1}}}))
      iar_code = '1;
    else
      iar_code = sum[WMAX-1:0];
  endfunction

  assign int_edge = link.integration_toggle ^ tog_prev_reg;
  assign fmt_wide = link.cfg_word[`IAR_CFG_FORMAT];
  assign tick     = link.cfg_word[`IAR_CFG_CLKDIV] ? (div_reg == 2'(`IAR_CLKDIV_RATIO - 1)) : 1'b1;
  assign finish   = busy_reg && tick && (tick_cnt_reg == 16'(INTEGRATION_TOGGLE_TICKS - 1));
  assign sc_rise  = link.shift_clock && !sc_prev_reg;
  assign integration_toggle_busy_o            = busy_reg;
  assign link.conversion_done_n = done_n_reg;
  assign link.data_out          = sr_reg[SR_W-1];

  // Edge history of the two control pins.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tog_prev_reg <= 1'b0;
      sc_prev_reg  <= 1'b0;
      div_reg      <= 2'h0;
    end
    else
    begin
      tog_prev_reg <= link.integration_toggle;
      sc_prev_reg  <= link.shift_clock;
      div_reg      <= div_reg + 2'h1;
    end
  end

  // Conversion timer; an edge during a conversion restarts it, so too short a period loses data.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_reg     <= 1'b0;
      tick_cnt_reg <= 16'h0000;
    end
    else if (int_edge)
    begin
      busy_reg     <= 1'b1;
      tick_cnt_reg <= 16'h0000;
    end
    else if (finish)
      busy_reg <= 1'b0;
    else if (busy_reg && tick)
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      done_n_reg <= 1'b1;
    else
      done_n_reg <= !finish;
  end

  // Pack channel words MSB first, channel 0 first.
  always_comb
  begin
    logic [WMAX-1:0] code_v;
    code_v   = '0;
    load_vec = '0;
    for (int ch = 0; ch < CH; ch++)
    begin
      code_v = iar_code(charge_i[ch*(WMAX+1) +: WMAX+1]);
      if (fmt_wide)
        load_vec[SR_W-1-ch*WMAX -: WMAX] = code_v;
      else
        load_vec[SR_W-1-ch*16 -: 16] = code_v[WMAX-1 -: 16];
    end
  end

  // Chain input enters right behind the last used bit so narrow words stay contiguous.
  always_comb
  begin
    shift_next = {sr_reg[SR_W-2:0], 1'b0};
    if (fmt_wide)
      shift_next[0] = link.chain_in;
    else
      shift_next[SR_W-CH*16] = link.chain_in;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sr_reg <= '0;
    else if (finish)
      sr_reg <= load_vec;
    else if (sc_rise)
      sr_reg <= shift_next;
  end
endmodule

// file: design/iar_ctrl.sv
// Controller end: configuration word, integration timing and serial readout of chained converters.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "iar_params.svh"
module iar_ctrl
  import iar_pkg::*;
#(
  parameter int LAT_CYC    = `IAR_INTEGRATION_TOGGLE_LATENCY_CYC,
  parameter int SHIFT_HALF = `IAR_SHIFT_HALF_CYC
)
(
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // Link to the converter chain.
  iar_link_if.ctrl         link,
  // Register port.
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // Result stream and interrupt.
  output logic [19:0]      word_o,
  output logic             word_valid_o,
  output logic             irq_o
);
  import iar_pkg::*;

  iar_state_e   state_reg;
  iar_state_e   state_next;
  logic [7:0]   ctrl_reg;
  logic [23:0]  half_reg;
  logic [9:0]   chans_reg;
  iar_events_t  status_reg;
  iar_events_t  irq_en_reg;
  iar_events_t  ev_set;
  logic [31:0]  rdata_reg;
  logic [23:0]  int_cnt_reg;
  logic         tog_reg;
  logic [31:0]  lat_cnt_reg;
  logic         lat_run_reg;
  logic         done_prev_reg;
  logic [7:0]   phase_reg;
  logic         sc_reg;
  logic [14:0]  bit_cnt_reg;
  logic [4:0]   wbit_reg;
  logic [19:0]  wsr_reg;
  logic [19:0]  word_reg;
  logic         wvalid_reg;
  logic         int_edge;
  logic         done_fall;
  logic         lat_hit;
  logic         ready;
  logic         phase_end;
  logic         shift_end;
  logic [4:0]   width;
  logic [14:0]  total;
  logic         run;
  logic         early;

  // Word width chosen by the format bit.
  function automatic logic [4:0] iar_width(input logic wide);
    iar_width = wide ? 5'(`IAR_WIDTH_WIDE) : 5'(`IAR_WIDTH_NARROW);
  endfunction

  function automatic logic [14:0] iar_total(input logic [9:0] chans, input logic wide);
    iar_total = 15'(chans * iar_width(wide));
  endfunction

  assign run    = ctrl_reg[`IAR_CTRL_RUN];
  assign early  = ctrl_reg[`IAR_CTRL_EARLY_READ];
  assign width  = iar_width(ctrl_reg[`IAR_CTRL_FORMAT]);
  assign total  = iar_total(chans_reg, ctrl_reg[`IAR_CTRL_FORMAT]);
  assign int_edge  = run && (int_cnt_reg >= half_reg - 24'h000001);
  assign done_fall = done_prev_reg && !link.conversion_done_n;
  assign lat_hit   = lat_run_reg && (lat_cnt_reg == 32'(LAT_CYC - 1));
  assign ready     = ctrl_reg[`IAR_CTRL_FIXED_WAIT] ? lat_hit : done_fall;
  assign phase_end = (phase_reg == 8'(SHIFT_HALF - 1));
  assign shift_end = (state_reg == IAR_SHIFT) && phase_end && sc_reg && (bit_cnt_reg == total);

  // Configuration word; range, version and divide come straight from the control register.
  always_comb
  begin
    link.cfg_word = 16'h0000;
    link.cfg_word[`IAR_CFG_RANGE_HI] = ctrl_reg[`IAR_CTRL_RANGE_HI];
    link.cfg_word[`IAR_CFG_RANGE_LO] = ctrl_reg[`IAR_CTRL_RANGE_LO];
    link.cfg_word[`IAR_CFG_FORMAT]   = ctrl_reg[`IAR_CTRL_FORMAT];
    link.cfg_word[`IAR_CFG_VERSION]  = ctrl_reg[`IAR_CTRL_VERSION];
    link.cfg_word[`IAR_CFG_CLKDIV]   = ctrl_reg[`IAR_CTRL_CLKDIV];
  end

  assign link.integration_toggle = tog_reg;
  assign link.shift_clock        = sc_reg;
  assign reg_rdata_o  = rdata_reg;
  assign word_o       = word_reg;
  assign word_valid_o = wvalid_reg;
  assign irq_o        = |(status_reg & irq_en_reg);

  // Software-written registers.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_reg   <= 8'h00;
      half_reg   <= `IAR_INT_HALF_RESET;
      chans_reg  <= `IAR_CHANS_RESET;
      irq_en_reg <= 3'h0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `IAR_REG_CTRL:     ctrl_reg   <= reg_wdata_i[7:0];
        `IAR_REG_INT_HALF: half_reg   <= reg_wdata_i[23:0];
        `IAR_REG_CHANS:    chans_reg  <= reg_wdata_i[9:0];
        `IAR_REG_IRQ_EN:   irq_en_reg <= reg_wdata_i[2:0];
        default:           ;
      endcase
    end
  end

  // Sticky events; a new event in the clearing cycle survives.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      status_reg <= 3'h0;
    else if (reg_wr_i && (reg_addr_i == `IAR_REG_IRQ_CLR))
      status_reg <= (status_reg & ~reg_wdata_i[2:0]) | ev_set;
    else
      status_reg <= status_reg | ev_set;
  end

  // Read data stand one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_reg <= 32'h00000000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `IAR_REG_CTRL:     rdata_reg <= {24'h000000, ctrl_reg};
        `IAR_REG_INT_HALF: rdata_reg <= {8'h00, half_reg};
        `IAR_REG_CHANS:    rdata_reg <= {22'h000000, chans_reg};
        `IAR_REG_STATUS:   rdata_reg <= {21'h000000, state_reg, 5'h00, status_reg};
        `IAR_REG_IRQ_EN:   rdata_reg <= {29'h00000000, irq_en_reg};
        default:           rdata_reg <= 32'h00000000;
      endcase
    end
    else
      rdata_reg <= 32'h00000000;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      int_cnt_reg <= 24'h000000;
      tog_reg     <= 1'b0;
    end
    else if (!run)
      int_cnt_reg <= 24'h000000;
    else if (int_edge)
    begin
      int_cnt_reg <= 24'h000000;
      tog_reg     <= !tog_reg;
    end
    else
      int_cnt_reg <= int_cnt_reg + 24'h000001;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lat_cnt_reg   <= 32'h00000000;
      lat_run_reg   <= 1'b0;
      done_prev_reg <= 1'b1;
    end
    else
    begin
      done_prev_reg <= link.conversion_done_n;
      if (int_edge)
      begin
        lat_cnt_reg <= 32'h00000000;
        lat_run_reg <= 1'b1;
      end
      else if (lat_hit)
        lat_run_reg <= 1'b0;
      else if (lat_run_reg)
        lat_cnt_reg <= lat_cnt_reg + 32'h00000001;
    end
  end

  // Sequencer: wait for results unless early read is set, then shift them out.
  always_comb
  begin
    state_next = state_reg;
    ev_set     = 3'h0;
    ev_set[`IAR_EV_DONE]    = ready;
    ev_set[`IAR_EV_READOUT] = shift_end;
    case (state_reg)
      IAR_IDLE:
        if (int_edge)
          state_next = early ? IAR_SHIFT : IAR_WAIT;
      IAR_WAIT:
        if (int_edge)
          ev_set[`IAR_EV_OVERRUN] = 1'b1;
        else if (ready)
          state_next = IAR_SHIFT;
      IAR_SHIFT:
        if (int_edge && !early)
        begin
          ev_set[`IAR_EV_OVERRUN] = 1'b1;
          state_next = IAR_WAIT;
        end
        else if (shift_end)
          state_next = IAR_IDLE;
      default:
        state_next = IAR_IDLE;
    endcase
    if (!run)
      state_next = IAR_IDLE;
  end

  // State register.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_reg <= IAR_IDLE;
    else
      state_reg <= state_next;
  end

  // Shift clock: sample the return line just before each rising edge, since the chain moves on it.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      phase_reg   <= 8'h00;
      sc_reg      <= 1'b0;
      bit_cnt_reg <= 15'h0000;
      wbit_reg    <= 5'h00;
      wsr_reg     <= 20'h00000;
      word_reg    <= 20'h00000;
      wvalid_reg  <= 1'b0;
    end
    else
    begin
      wvalid_reg <= 1'b0;
      if (state_reg != IAR_SHIFT || state_next != IAR_SHIFT)
      begin
        phase_reg   <= 8'h00;
        sc_reg      <= 1'b0;
        bit_cnt_reg <= 15'h0000;
        wbit_reg    <= 5'h00;
      end
      else if (!phase_end)
        phase_reg <= phase_reg + 8'h01;
      else
      begin
        phase_reg <= 8'h00;
        if (sc_reg)
          sc_reg <= 1'b0;
        else if (bit_cnt_reg != total)
        begin
          sc_reg      <= 1'b1;
          bit_cnt_reg <= bit_cnt_reg + 15'h0001;
          wsr_reg     <= {wsr_reg[18:0], link.data_out};
          if (wbit_reg == width - 5'h01)
          begin
            wbit_reg   <= 5'h00;
            word_reg   <= {wsr_reg[18:0], link.data_out} & ((20'h00001 << width) - 20'h00001);
            wvalid_reg <= 1'b1;
          end
          else
            wbit_reg <= wbit_reg + 5'h01;
        end
      end
    end
  end
endmodule

// file: testbench/iar_link_props.sv
// Concurrent checks on the link between the converter and its controller.
`timescale 1ns/10ps
module iar_link_props
#(
  parameter int TICKS = 20
)
(
  // Clock and reset.
  input wire logic             clock_i,
  input wire logic             rst_b_i,
  // Link signals.
  input wire logic             integration_toggle,
  input wire logic             shift_clock,
  input wire iar_pkg::iar_cfg_t cfg_word,
  input wire logic             conversion_done_n,
  input wire logic             data_out
);
  import iar_pkg::*;
  localparam int DONE_MAX = 4 * TICKS + 8;
  logic        tog_q;
  logic [15:0] since_edge;

  // Cycles since the last toggle edge; saturates so a long idle never wraps into a false match.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tog_q      <= 1'b0;
      since_edge <= 16'h0000;
    end
    else
    begin
      tog_q <= integration_toggle;
      if (integration_toggle != tog_q)
        since_edge <= 16'h0000;
      else if (since_edge != 16'hFFFF)
        since_edge <= since_edge + 16'h0001;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_edge;
    $changed(integration_toggle);
  endsequence
  sequence s_done;
    $fell(conversion_done_n);
  endsequence

  property p_every_edge_converts;
    s_edge |-> ##[1:DONE_MAX] s_done;
  endproperty
  property p_toggle_holds;
    s_edge |=> $stable(integration_toggle) [*8];
  endproperty
  property p_done_one_cycle;
    s_done |=> conversion_done_n;
  endproperty
  property p_integration_toggle_undivided;
    s_done and !cfg_word[13] |-> since_edge >= TICKS - 2 && since_edge <= TICKS + 3;
  endproperty
  property p_integration_toggle_divided;
    s_done and cfg_word[13] |-> since_edge >= 4 * TICKS - 5 && since_edge <= 4 * TICKS + 6;
  endproperty
  property p_data_moves_on_shift;
    $changed(data_out) |-> $past(shift_clock) || !$past(conversion_done_n) || !conversion_done_n;
  endproperty
  property p_shift_high_half;
    $rose(shift_clock) |=> shift_clock || $changed(integration_toggle);
  endproperty
  property p_cfg_fields;
    cfg_word[15:14] == 2'b00 && cfg_word[12:11] == 2'b00 && cfg_word[6:0] == 7'h00;
  endproperty

  a_every_edge_converts:
    assert property (p_every_edge_converts) else $error("toggle edge not followed by a conversion");
  a_toggle_holds:
    assert property (p_toggle_holds) else $error("toggle edges too close together");
  a_done_one_cycle:
    assert property (p_done_one_cycle) else $error("done pulse longer than one cycle");
  a_integration_toggle_undivided:
    assert property (p_integration_toggle_undivided) else $error("undivided conversion time off");
  a_integration_toggle_divided:
    assert property (p_integration_toggle_divided) else $error("divided conversion time off");
  a_data_moves_on_shift:
    assert property (p_data_moves_on_shift) else $error("serial output moved without a shift");
  a_shift_high_half:
    assert property (p_shift_high_half) else $error("shift clock high phase too short");
  a_cfg_fields:
    assert property (p_cfg_fields) else $error("fixed configuration bits not zero");
endmodule

// file: testbench/integrating_adc_readout_sequencing_test.sv
// Self-checking bench joining one converter and its controller over the link.
`timescale 1ns/10ps
`include "iar_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module integrating_adc_readout_sequencing_test;
  import iar_pkg::*;
  localparam int T = 20;
  logic        clock_i    = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic [31:0] wdata      = 32'h0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [41:0] charge     = 42'h0;
  logic [31:0] rdata;
  logic [19:0] word;
  logic        word_valid;
  logic        irq;
  logic        busy;
  logic [31:0] rv;
  logic [19:0] words[$];
  int          num_errors = 0;
  int          checked    = 0;
  int          cyc        = 0;
  int          edge_cyc   = 0;
  int          rise_cyc   = 0;
  int          rises      = 0;
  logic        first      = 1'b0;
  logic        rise_busy  = 1'b0;
  logic        tog_q      = 1'b0;
  logic        sc_q       = 1'b0;

  iar_link_if link();
  iar_device #(.CH(2), .INTEGRATION_TOGGLE_TICKS(T)) iar_device_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link),
    .charge_i(charge), .integration_toggle_busy_o(busy));
  iar_ctrl #(.LAT_CYC(100), .SHIFT_HALF(2)) iar_ctrl_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .word_o(word), .word_valid_o(word_valid), .irq_o(irq));
  iar_link_props #(.TICKS(T)) iar_link_props_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .integration_toggle(link.integration_toggle), .shift_clock(link.shift_clock), .cfg_word(link.cfg_word),
    .conversion_done_n(link.conversion_done_n), .data_out(link.data_out));

  // Upstream chain feeds ones, so the third word of a readout is known.
  initial link.chain_in = 1'b1;
  always #4 clock_i = ~clock_i;

  // Watch edges, shift clock rises and words; a readout belongs to the edge before it.
  always @(posedge clock_i)
  begin
    cyc   <= cyc + 1;
    tog_q <= link.integration_toggle;
    sc_q  <= link.shift_clock;
    if (link.integration_toggle !== tog_q)
    begin
      edge_cyc <= cyc;
      rises    <= 0;
      first    <= 1'b1;
    end
    else if (link.shift_clock === 1'b1 && sc_q === 1'b0)
    begin
      rises <= rises + 1;
      if (first)
      begin
        rise_cyc  <= cyc;
        rise_busy <= busy;
        first     <= 1'b0;
      end
    end
    if (word_valid === 1'b1)
      words.push_back(word);
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    @(negedge clock_i);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(negedge clock_i);
    d = rdata;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000)
    begin
      @(negedge clock_i);
      n++;
    end
    `CHK("irq", 1'b1, irq)
  endtask

  // Expected code: charge lifted by the headroom offset, clamped to the 20-bit range.
  function automatic logic [19:0] exp_code(input int idx);
    int v;
    if (idx > 1)
      return 20'hFFFFF;
    v = $signed(charge[idx * 21 +: 21]) + (1 << 20) * `IAR_HEADROOM_NUM / `IAR_HEADROOM_DEN;
    return (v < 0) ? 20'h00000 : (v > 32'h000FFFFF) ? 20'hFFFFF : v[19:0];
  endfunction

  task automatic t_regs();
    reg_rd(`IAR_REG_INT_HALF, rv);
    `CHK("int_half", 32'h0000F424, rv)
    reg_rd(`IAR_REG_CHANS, rv);
    `CHK("chans", 32'h00000080, rv)
    reg_rd(8'h1C, rv);
    `CHK("unmapped", 32'h0, rv)
    `CHK("cfg reset", 16'h0000, link.cfg_word)
    reg_wr(`IAR_REG_INT_HALF, 32'd400);
    reg_wr(`IAR_REG_CHANS, 32'd3);
    reg_wr(`IAR_REG_IRQ_EN, 32'h2);
  endtask

  task automatic t_cfg();
    logic [7:0] tbl[4];
    tbl = '{8'hFE, 8'h0C, 8'h20, 8'h12};
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(`IAR_REG_CTRL, {24'h0, tbl[i]});
      `CHK("cfg", {2'b00, tbl[i][5], 2'b00, tbl[i][3:2], tbl[i][1], tbl[i][4], 7'h00}, link.cfg_word)
    end
  endtask

  // One readout: start-to-shift delay, bit count, word values and the completion event.
  task automatic run_once(input logic [7:0] ctl, input int lo, input int hi, input bit vals);
    int w;
    w = ctl[1] ? 20 : 16;
    words.delete();
    reg_wr(`IAR_REG_CTRL, {24'h0, ctl});
    wait_irq();
    reg_wr(`IAR_REG_CTRL, 32'h0);
    `CHK("start", 1'b1, rise_cyc - edge_cyc >= lo && rise_cyc - edge_cyc <= hi)
    `CHK("busy at shift", ctl[7], rise_busy)
    `CHK("bits", 3 * w, rises)
    `CHK("words", 3, words.size())
    for (int i = 0; i < 3 && vals; i++)
      `CHK("word", w == 20 ? exp_code(i) : exp_code(i) >> 4, w == 20 ? words[i] : {4'h0, words[i][15:0]})
    reg_rd(`IAR_REG_STATUS, rv);
    `CHK("readout", 1'b1, rv[`IAR_EV_READOUT])
    reg_wr(`IAR_REG_IRQ_CLR, 32'h7);
    `CHK("irq clear", 1'b0, irq)
  endtask

  // Edges every 30 cycles cut the readout short; then mask and clear the interrupt.
  task automatic t_overrun();
    reg_wr(`IAR_REG_INT_HALF, 32'd30);
    reg_wr(`IAR_REG_IRQ_EN, 32'h4);
    reg_wr(`IAR_REG_CTRL, 32'h3);
    wait_irq();
    reg_wr(`IAR_REG_CTRL, 32'h0);
    reg_rd(`IAR_REG_STATUS, rv);
    `CHK("overrun", 1'b1, rv[`IAR_EV_OVERRUN])
    reg_wr(`IAR_REG_IRQ_EN, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    reg_wr(`IAR_REG_IRQ_EN, 32'h1);
    `CHK("irq done", 1'b1, irq)
    reg_wr(`IAR_REG_IRQ_CLR, 32'h7);
    `CHK("irq cleared", 1'b0, irq)
  endtask

  task automatic test_done();
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence: negative and saturating charges first, then a pair whose negative charge clamps to zero.
  initial
  begin
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    charge  <= {21'h0FFFFF, -21'sd100};
    t_regs();
    t_cfg();
    run_once(8'h0F, T, T + 10, 1'b1);
    charge <= {21'd12345, -21'sd5000};
    run_once(8'h21, 4 * T, 4 * T + 16, 1'b1);
    run_once(8'h43, 98, 108, 1'b1);
    run_once(8'h83, 1, 6, 1'b0);
    t_overrun();
    test_done();
  end

  // A hang counts as a failure.
  initial
  begin
    #400000;
    num_errors++;
    test_done();
  end
endmodule
